// ==== bench/cwr_core_props.sv ====
// Assertion checker for the core working register file.
`timescale 1ns/1ps
`default_nettype none
module cwr_core_props (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Watched outputs.
    input wire logic [15:0] o_pc,
    input wire logic o_fetch_strobe,
    input wire logic [15:0] o_status,
    input wire logic [15:0] o_stack_ptr,
    input wire logic o_busy
);
    logic [1:0] up_reg;
    logic [5:0] busy_cnt_reg;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            up_reg <= 2'h0;
            busy_cnt_reg <= 6'h00;
        end else begin
            up_reg <= (up_reg == 2'h3) ? 2'h3 : up_reg + 2'h1;
            busy_cnt_reg <= o_busy ? busy_cnt_reg + 6'h01 : 6'h00;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_sp_reset: assert property (up_reg == 2'h0 |-> o_stack_ptr == 16'h0800)
        else $error("stack pointer reset");
    a_pc_step: assert property ($changed(o_pc) |-> o_pc == $past(o_pc) + 16'h0001)
        else $error("pc step");
    a_pc_pace: assert property ($changed(o_pc) |=> $stable(o_pc))
        else $error("pc pace");
    a_pc_rate: assert property ((up_reg == 2'h3 && !o_busy) [*4] |-> o_pc == $past(o_pc, 2) + 16'h0001)
        else $error("pc rate");
    a_div_hold: assert property (o_busy && $past(o_busy) |-> $stable(o_pc))
        else $error("pc moved in divide");
    a_div_nofetch: assert property (o_busy |-> !o_fetch_strobe)
        else $error("fetch in divide");
    a_div_length: assert property (up_reg == 2'h3 && $fell(o_busy) |-> busy_cnt_reg == 6'h26)
        else $error("divide length");
    a_fetch_gap: assert property (o_fetch_strobe |=> !o_fetch_strobe)
        else $error("fetch gap");
    a_fetch_each: assert property ((up_reg == 2'h3 && !o_busy) [*4] |-> o_fetch_strobe || $past(o_fetch_strobe))
        else $error("fetch missing");
    a_busy_flag: assert property (o_busy |-> o_status[0])
        else $error("status busy bit");
    c_div: cover property ($fell(o_busy));
    c_fetch: cover property (o_fetch_strobe ##2 o_fetch_strobe);
    c_pc: cover property (o_pc == 16'h000D);
endmodule
bind cwr_core cwr_core_props u_props (.i_clk(i_clk), .i_reset_n(i_reset_n), .o_pc(o_pc),
    .o_fetch_strobe(o_fetch_strobe), .o_status(o_status), .o_stack_ptr(o_stack_ptr), .o_busy(o_busy));
`default_nettype wire

// ==== bench/cwr_core_tb.sv ====
// Self-checking testbench for the core working register file.
`timescale 1ns/1ps
`default_nettype none
module cwr_core_tb;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [23:0] i_insn = 24'h000000;
    logic [15:0] o_pc, o_status, o_core_control, o_frame_ptr, o_stack_ptr, o_default_accumulator;
    logic o_fetch_strobe, o_busy;
    logic [23:0] prog [0:31];
    logic [15:0] exp_q [$];
    logic [15:0] prev_acc = 16'h0000;
    logic [15:0] a, b, c, q, r;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'h2D27C58C;
    cwr_core u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_insn(i_insn), .o_pc(o_pc),
        .o_fetch_strobe(o_fetch_strobe), .o_status(o_status), .o_core_control(o_core_control),
        .o_frame_ptr(o_frame_ptr), .o_stack_ptr(o_stack_ptr),
        .o_default_accumulator(o_default_accumulator), .o_busy(o_busy));
    always #4 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [23:0] enc(input logic [3:0] op, input logic [3:0] d, input logic [3:0] s,
        input logic [7:0] k);
        return {op, d, s, 4'h0, k};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Program memory answers the current program counter.
    always @(posedge i_clk) begin
        #1;
        i_insn = (o_pc < 16'h0020) ? prog[o_pc[4:0]] : 24'h000000;
    end
    // Every change of the accumulator retires the oldest expectation.
    always @(negedge i_clk) begin
        if (i_reset_n && o_default_accumulator !== prev_acc) begin
            prev_acc = o_default_accumulator;
            check(o_default_accumulator, exp_q.size() != 0 ? exp_q.pop_front() : ~o_default_accumulator);
        end
    end
    initial begin
        #24000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        do begin
            a = 16'h0002 + 16'({$random(seed)} % 200);
            b = 16'h0002 + 16'({$random(seed)} % 200);
            c = 16'h0002 + 16'({$random(seed)} % 200);
            q = a * b / c;
            r = a * b % c;
        end while (a == b || c == a * b || q == r);
        foreach (prog[i]) prog[i] = 24'h000000;
        // Word zero is shadowed by the cleared input synchroniser, so it stays a no-op.
        prog[1] = enc(cwr_pkg::CWR_OP_LIT, 4'h0, 4'h0, a[7:0]);
        prog[2] = enc(cwr_pkg::CWR_OP_MOV, 4'h1, 4'h0, 8'h00);
        prog[3] = enc(cwr_pkg::CWR_OP_LIT, 4'h0, 4'h0, b[7:0]);
        prog[4] = enc(cwr_pkg::CWR_OP_MUL, 4'h1, 4'h0, 8'h00);
        prog[5] = enc(cwr_pkg::CWR_OP_ACCLD, 4'h0, 4'h2, 8'h00);
        prog[6] = enc(cwr_pkg::CWR_OP_LIT, 4'h0, 4'h0, c[7:0]);
        prog[7] = enc(cwr_pkg::CWR_OP_MOV, 4'h1, 4'h0, 8'h00);
        prog[8] = enc(cwr_pkg::CWR_OP_ACCLD, 4'h0, 4'h2, 8'h00);
        prog[9] = enc(cwr_pkg::CWR_OP_DIV, 4'h0, 4'h0, 8'h00);
        prog[10] = enc(cwr_pkg::CWR_OP_ACCLD, 4'h0, 4'h1, 8'h00);
        prog[11] = enc(cwr_pkg::CWR_OP_MOV, 4'hE, 4'h0, 8'h00);
        prog[12] = enc(cwr_pkg::CWR_OP_MOV, 4'hF, 4'h0, 8'h00);
        prog[13] = enc(cwr_pkg::CWR_OP_WRCTL, 4'h0, 4'h0, 8'h00);
        exp_q = '{a, b, a * b, c, a * b, q, r};
        repeat (12) @(posedge i_clk);
        check(o_stack_ptr, 16'h0800);
        #1;
        i_reset_n = 1'b1;
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge i_clk);
        repeat (12) @(posedge i_clk);
        check(16'(exp_q.size()), 16'h0000);
        check(o_frame_ptr, r);
        check(o_stack_ptr, r);
        check(o_core_control, r);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== design/cwr_consts.svh ====
// Constants for the core working register file.
`ifndef CWR_CONSTS_SVH
`define CWR_CONSTS_SVH
`define CWR_INSN_W 24
`define CWR_DATA_W 16
`define CWR_NUM_REGS 16
`define CWR_IDX_ACC 4'h0
`define CWR_IDX_DIV_LO 4'h0
`define CWR_IDX_DIV_HI 4'h1
`define CWR_IDX_MUL_LO 4'h2
`define CWR_IDX_MUL_HI 4'h3
`define CWR_IDX_FP 4'hE
`define CWR_IDX_SP 4'hF
`define CWR_CLK_PER_CYC 2'h2
`define CWR_DIV_CYCLES 5'h13
`define CWR_DIV_ITER 5'h10
`define CWR_BYTE_SHMAX 4'h7
`define CWR_WORD_SHMAX 4'hF
`define CWR_OP_POS 20
`define CWR_DST_POS 16
`define CWR_SRC_POS 12
`define CWR_SH_POS 8
`define CWR_SP_RESET 16'h0800
`endif

// ==== design/cwr_core.sv ====
// Working register file with two-clock instruction cycle and overlapped fetch.
// How it works
// - Instruction words are 24 bits each.
// - Two clocks per cycle; PC advances first.
// - Fetch and execute take one cycle each.
// - Sixteen working registers, any source or destination.
// - Accumulator-only instructions use register zero.
// - Registers zero and one serve divide.
// - Multiply result goes to registers two, three.
// - Register fourteen frame, fifteen stack pointer.
// - Division iterates under a repeat loop.
// - Shifter moves up to fifteen bits.
// - Status and core control registers hold state.
// - Divide completes in nineteen instruction cycles.
// - Multiply completes in one instruction cycle.
// - Byte rotate seven, word rotate fifteen.
`include "cwr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cwr_core (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Instruction memory.
    input wire logic [`CWR_INSN_W-1:0] i_insn,
    output logic [15:0] o_pc,
    output logic o_fetch_strobe,
    // Core state.
    output logic [15:0] o_status,
    output logic [15:0] o_core_control,
    output logic [15:0] o_frame_ptr,
    output logic [15:0] o_stack_ptr,
    output logic [15:0] o_default_accumulator,
    output logic o_busy
);
    ////////////////////////////////////////////////////////////////////////////
    cwr_pkg::cwr_state_t s_reg;
    cwr_pkg::cwr_state_t s_next;
    logic [23:0] insn_sync1_reg;
    logic [23:0] insn_sync2_reg;
    cwr_pkg::cwr_op_t op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [3:0] shamt;
    logic byte_mode;
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] prod;
    logic [15:0] shres;
    logic [3:0] samt;
    logic [16:0] trial;

    // Instruction word arrives from outside; resynchronise it.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            insn_sync1_reg <= 24'h000000;
            insn_sync2_reg <= 24'h000000;
        end else begin
            insn_sync1_reg <= i_insn;
            insn_sync2_reg <= insn_sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode fields of the 24-bit word in the execute stage.
    always_comb begin
        op = cwr_pkg::cwr_op_t'(s_reg.exec_reg[`CWR_OP_POS+3:`CWR_OP_POS]);
        dst = s_reg.exec_reg[`CWR_DST_POS+3:`CWR_DST_POS];
        src = s_reg.exec_reg[`CWR_SRC_POS+3:`CWR_SRC_POS];
        shamt = s_reg.exec_reg[`CWR_SH_POS+3:`CWR_SH_POS];
        byte_mode = s_reg.exec_reg[7];
        a = s_reg.working_reg_array[dst];
        b = s_reg.working_reg_array[src];
        prod = (op == cwr_pkg::CWR_OP_MULSU) ? 32'($signed(a) * $signed({1'b0, b}))
                                             : 32'($signed(a) * $signed(b));
        samt = shamt;
        if (byte_mode && samt > `CWR_BYTE_SHMAX) begin
            samt = `CWR_BYTE_SHMAX;
        end
        shres = 16'h0000;
        case (op)
            cwr_pkg::CWR_OP_SHL: shres = a << samt;
            cwr_pkg::CWR_OP_SHR: shres = a >> samt;
            cwr_pkg::CWR_OP_ROL: begin
                if (byte_mode) begin
                    shres = {8'h00, 8'(({a[7:0], a[7:0]} << samt) >> 8)};
                end else begin
                    shres = 16'(({a, a} << samt) >> 16);
                end
            end
            cwr_pkg::CWR_OP_ROR: begin
                if (byte_mode) begin
                    shres = {8'h00, 8'({a[7:0], a[7:0]} >> samt)};
                end else begin
                    shres = 16'({a, a} >> samt);
                end
            end
            default: shres = 16'h0000;
        endcase
        trial = {s_reg.div_rem[14:0], s_reg.div_quo[15]} - {1'b0, s_reg.div_dvsr};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        s_next = s_reg;
        s_next.tcy_phase = ~s_reg.tcy_phase;
        if (!s_reg.tcy_phase) begin
            // Leading clock of the instruction cycle: PC advances unless dividing.
            if (s_reg.phase != cwr_pkg::CWR_ST_DIV) begin
                s_next.pc = s_reg.pc + 16'h0001;
            end
        end else begin
            case (s_reg.phase)
                cwr_pkg::CWR_ST_FETCH: begin
                    s_next.fetch_reg = insn_sync2_reg;
                    s_next.phase = cwr_pkg::CWR_ST_EXEC;
                end
                cwr_pkg::CWR_ST_EXEC: begin
                    s_next.fetch_reg = insn_sync2_reg;
                    s_next.exec_reg = s_reg.fetch_reg;
                    s_next.exec_valid = 1'b1;
                    if (s_reg.exec_valid) begin
                        case (op)
                            cwr_pkg::CWR_OP_MOV: s_next.working_reg_array[dst] = b;
                            cwr_pkg::CWR_OP_ADD: s_next.working_reg_array[dst] = a + b;
                            cwr_pkg::CWR_OP_SUB: s_next.working_reg_array[dst] = a - b;
                            cwr_pkg::CWR_OP_MUL, cwr_pkg::CWR_OP_MULSU: begin
                                s_next.working_reg_array[`CWR_IDX_MUL_LO] = prod[15:0];
                                s_next.working_reg_array[`CWR_IDX_MUL_HI] = prod[31:16];
                            end
                            cwr_pkg::CWR_OP_SHL, cwr_pkg::CWR_OP_SHR, cwr_pkg::CWR_OP_ROL,
                            cwr_pkg::CWR_OP_ROR: s_next.working_reg_array[dst] = shres;
                            cwr_pkg::CWR_OP_ACCLD: begin
                                s_next.working_reg_array[`CWR_IDX_ACC] = b;
                            end
                            cwr_pkg::CWR_OP_LIT: begin
                                s_next.working_reg_array[`CWR_IDX_ACC] = {8'h00, s_reg.exec_reg[7:0]};
                            end
                            cwr_pkg::CWR_OP_WRSTAT: s_next.status_reg = b;
                            cwr_pkg::CWR_OP_WRCTL: s_next.core_control_reg = b;
                            cwr_pkg::CWR_OP_DIV: begin
                                // Dividend in register zero, divisor in register one.
                                s_next.div_quo = s_reg.working_reg_array[`CWR_IDX_DIV_LO];
                                s_next.div_dvsr = s_reg.working_reg_array[`CWR_IDX_DIV_HI];
                                s_next.div_rem = 16'h0000;
                                s_next.div_count = `CWR_DIV_CYCLES - 5'h1;
                                s_next.status_reg[0] = 1'b1;
                                s_next.phase = cwr_pkg::CWR_ST_DIV;
                                // Keep both queued words so that none is lost while the PC is frozen.
                                s_next.exec_valid = 1'b0;
                                s_next.exec_reg = s_reg.fetch_reg;
                                s_next.fetch_reg = insn_sync2_reg;
                            end
                            default: s_next.exec_valid = 1'b1;
                        endcase
                    end
                end
                cwr_pkg::CWR_ST_DIV: begin
                    // One quotient bit per instruction cycle for the first sixteen cycles, repeat-driven.
                    s_next.div_count = s_reg.div_count - 5'h1;
                    if (s_reg.div_count > (`CWR_DIV_CYCLES - `CWR_DIV_ITER - 5'h1)) begin
                        if (!trial[16]) begin
                            s_next.div_rem = trial[15:0];
                        end else begin
                            s_next.div_rem = {s_reg.div_rem[14:0], s_reg.div_quo[15]};
                        end
                        s_next.div_quo = {s_reg.div_quo[14:0], ~trial[16]};
                    end
                    if (s_reg.div_count == 5'h00) begin
                        s_next.working_reg_array[`CWR_IDX_DIV_LO] = s_reg.div_quo;
                        s_next.working_reg_array[`CWR_IDX_DIV_HI] = s_reg.div_rem;
                        s_next.status_reg[0] = 1'b0;
                        s_next.phase = cwr_pkg::CWR_ST_EXEC;
                        s_next.exec_valid = 1'b1;
                    end
                end
                default: s_next.phase = cwr_pkg::CWR_ST_FETCH;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_reg <= '0;
            s_reg.working_reg_array[`CWR_IDX_SP] <= `CWR_SP_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign o_pc = s_reg.pc;
    assign o_fetch_strobe = s_reg.tcy_phase && (s_reg.phase != cwr_pkg::CWR_ST_DIV);
    assign o_status = s_reg.status_reg;
    assign o_core_control = s_reg.core_control_reg;
    assign o_frame_ptr = s_reg.working_reg_array[`CWR_IDX_FP];
    assign o_stack_ptr = s_reg.working_reg_array[`CWR_IDX_SP];
    assign o_default_accumulator = s_reg.working_reg_array[`CWR_IDX_ACC];
    assign o_busy = (s_reg.phase == cwr_pkg::CWR_ST_DIV);
endmodule
`default_nettype wire

// ==== design/cwr_pkg.sv ====
// Types for the core working register file.
package cwr_pkg;
    typedef enum logic [3:0] {
        CWR_OP_NOP, CWR_OP_MOV, CWR_OP_ADD, CWR_OP_SUB, CWR_OP_MUL, CWR_OP_MULSU,
        CWR_OP_DIV, CWR_OP_SHL, CWR_OP_SHR, CWR_OP_ROL, CWR_OP_ROR, CWR_OP_ACCLD,
        CWR_OP_WRSTAT, CWR_OP_WRCTL, CWR_OP_LIT
    } cwr_op_t;
    typedef enum logic [1:0] {CWR_ST_FETCH, CWR_ST_EXEC, CWR_ST_DIV} cwr_phase_t;
    typedef struct packed {
        logic [15:0][15:0] working_reg_array;
        logic [15:0] status_reg;
        logic [15:0] core_control_reg;
        logic [23:0] fetch_reg;
        logic [23:0] exec_reg;
        logic exec_valid;
        logic [15:0] pc;
        logic tcy_phase;
        cwr_phase_t phase;
        logic [4:0] div_count;
        logic [15:0] div_rem;
        logic [15:0] div_quo;
        logic [15:0] div_dvsr;
    } cwr_state_t;
endpackage
